// File: rtl/char_lcd_pkg.sv
// Purpose: Shared constants and types for the character display instruction decoder
// Assumes: 40 MHz system clock, 270 kHz nominal internal oscillator for timing figures
// Notes: Times are kept in ns as printed; cycle counts derive from them
package char_lcd_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned OSC_HZ = 270_000;
  localparam int unsigned T_LONG_NS = 1_530_000;
  localparam int unsigned T_INSTR_NS = 39_000;
  localparam int unsigned T_DATA_NS = 43_000;
  // Least times, so round up
  localparam int unsigned LONG_CYC = (T_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned INSTR_CYC = (T_INSTR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DATA_CYC = (T_DATA_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HALF_OSC_CYC = (CLK_HZ + 2 * OSC_HZ - 1) / (2 * OSC_HZ);
  localparam int BUSY_W = 16;
  localparam int GUARD_W = 8;

  // ==========================================================================
  // Codes and field positions
  // ==========================================================================
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] HOME_ADDR = 7'h00;
  localparam logic [6:0] FILL_LAST = 7'h7f;
  localparam int DISP_ADDR_W = 7;
  localparam int GLYPH_ADDR_W = 6;
  localparam int B_INCR = 1;
  localparam int B_MOVE = 0;
  localparam int B_DISP = 2;
  localparam int B_CURS = 1;
  localparam int B_BLINK = 0;
  localparam int B_SC = 3;
  localparam int B_RL = 2;
  localparam int B_WIDTH = 4;
  localparam int B_LINES = 3;
  localparam int B_FONT = 2;

  localparam logic [7:0] PAT_DISP_ADDR = 8'b1???????;
  localparam logic [7:0] PAT_GLYPH_ADDR = 8'b01??????;
  localparam logic [7:0] PAT_FORMAT = 8'b001?????;
  localparam logic [7:0] PAT_SHIFT = 8'b0001????;
  localparam logic [7:0] PAT_CTRL = 8'b00001???;
  localparam logic [7:0] PAT_ENTRY = 8'b000001??;
  localparam logic [7:0] PAT_HOME = 8'b0000001?;
  localparam logic [7:0] PAT_CLEAR = 8'b00000001;

  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_CLEAR = 4'b0001,
    OP_HOME = 4'b0010,
    OP_ENTRY = 4'b0011,
    OP_CTRL = 4'b0100,
    OP_SHIFT = 4'b0101,
    OP_FORMAT = 4'b0110,
    OP_GLYPH_ADDR = 4'b0111,
    OP_DISP_ADDR = 4'b1000,
    OP_WRITE = 4'b1001,
    OP_READ = 4'b1010
  } op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_FILL = 1'b1
  } exec_state_e;

  // ==========================================================================
  // Wishbone register map
  // ==========================================================================
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_VIEW_ADDR = 4'h4;
  localparam logic [3:0] OFS_VIEW_DATA = 4'h8;
  localparam int S_BUSY = 7;
  localparam int S_DISP = 8;
  localparam int S_CURS = 9;
  localparam int S_BLINK = 10;
  localparam int S_INCR = 11;
  localparam int S_MOVE = 12;
  localparam int S_WIDTH = 13;
  localparam int S_LINES = 14;
  localparam int S_FONT = 15;
  localparam int S_OFFSET = 16;
  localparam int S_GLYPH = 23;

endpackage

// File: rtl/char_lcd_instruction_decoder.sv
// Purpose: Instruction decoder and executor of a character display controller
// Assumes: Host pins are asynchronous and are sampled through two flip-flops
// Notes: Panel drive state is observed over a small Wishbone slave
//
// Behaviour
// - Clear fills display RAM with spaces, zeroes the address counter, homes cursor.
// - Clear also forces the entry direction to increment.
// - Busy lasts 1.53ms for clear/home, 39us for others, none for a zero instruction byte (OP_NOP), 43us for data.
// - Home zeroes the address counter and undoes display shift, RAM untouched.
// - Entry mode stores direction and shift bits; direction picks plus or minus one.
// - Besides the shift instruction, whole display shifts only on display RAM writes with the shift bit set.
// - Glyph RAM accesses step the address in the stored direction too.
// - Display control loads display, cursor and blink bits from bits 2,1,0.
// - Busy reads high on the top bus line while an operation runs.
// - Status read returns busy and the seven-bit address counter, always allowed.
// - Half an oscillator period passes after busy falls before next execution.
// - Glyph address instruction loads six bits and selects glyph RAM.
// - Display address instruction loads seven bits and selects display RAM.
// - Format instruction stores bus width, line count and font height.
// - Data write stores to the selected RAM; data read returns from it.
// - Every RAM data access steps the address by one in stored direction.
// - Register select routes transfers to instruction or data register.
// - Shift instruction moves cursor or display without touching RAM, 39us.
// - In 4-bit mode each byte moves as two nibbles on the upper lines.
// - Display off blanks the screen while keeping display RAM intact.
// - Width bit high selects 8-bit transfers, low selects 4-bit transfers.
`timescale 1ns/1ps

module char_lcd_instruction_decoder
  import char_lcd_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = LONG_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic reg_select_i,
  input wire logic read_not_write_i,
  input wire logic strobe_i,
  input wire logic [7:0] bus_i,
  output logic [7:0] bus_o,
  output logic bus_oe_n_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [10:0] pin_s1_q;
  logic [10:0] pin_s2_q;
  logic en_prev_q;
  logic rs_s;
  logic rw_s;
  logic en_s;
  logic [7:0] db_s;
  logic strobe_fall;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 11'h000;
      pin_s2_q <= 11'h000;
      en_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {reg_select_i, read_not_write_i, strobe_i, bus_i};
      pin_s2_q <= pin_s1_q;
      en_prev_q <= pin_s2_q[8];
    end
  end

  assign rs_s = pin_s2_q[10];
  assign rw_s = pin_s2_q[9];
  assign en_s = pin_s2_q[8];
  assign db_s = pin_s2_q[7:0];
  assign strobe_fall = en_prev_q & ~en_s;

  // ==========================================================================
  // Mode state
  // ==========================================================================
  logic bus_width_sel_q;
  logic two_line_q;
  logic tall_font_q;
  logic display_on_q;
  logic cursor_on_q;
  logic blink_on_q;
  logic incr_q;
  logic whole_screen_move_q;

  // ==========================================================================
  // Nibble pairing
  // ==========================================================================
  logic nib_q;
  logic [3:0] hi_nib_q;
  logic xfer_go;
  logic [7:0] xfer_byte;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nib_q <= 1'b0;
      hi_nib_q <= 4'h0;
    end else if (bus_width_sel_q) begin
      nib_q <= 1'b0;
    end else if (strobe_fall) begin
      nib_q <= ~nib_q;
      if (!nib_q) begin
        hi_nib_q <= db_s[7:4];
      end
    end
  end

  // Byte completes on every strobe in 8-bit mode, every second in 4-bit mode
  assign xfer_go = strobe_fall & (bus_width_sel_q | nib_q);
  assign xfer_byte = bus_width_sel_q ? db_s : {hi_nib_q, db_s[7:4]};

  // ==========================================================================
  // Pending transfer and decode
  // ==========================================================================
  logic pend_q;
  logic pend_rs_q;
  logic pend_rd_q;
  logic [7:0] pend_byte_q;
  logic [BUSY_W-1:0] busy_cnt_q;
  logic [GUARD_W-1:0] guard_cnt_q;
  exec_state_e state_q;
  logic exec_go;
  logic busy_ind;
  op_e cmd;

  // A new transfer overwrites one still waiting; the host must poll first
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q <= 1'b0;
      pend_rs_q <= 1'b0;
      pend_rd_q <= 1'b0;
      pend_byte_q <= 8'h00;
    end else if (xfer_go && !(rw_s && !rs_s)) begin
      pend_q <= 1'b1;
      pend_rs_q <= rs_s;
      pend_rd_q <= rw_s;
      pend_byte_q <= xfer_byte;
    end else if (exec_go) begin
      pend_q <= 1'b0;
    end
  end

  always_comb begin
    cmd = OP_NOP;
    if (pend_rs_q) begin
      cmd = pend_rd_q ? OP_READ : OP_WRITE;
    end else begin
      casez (pend_byte_q)
        PAT_DISP_ADDR: cmd = OP_DISP_ADDR;
        PAT_GLYPH_ADDR: cmd = OP_GLYPH_ADDR;
        PAT_FORMAT: cmd = OP_FORMAT;
        PAT_SHIFT: cmd = OP_SHIFT;
        PAT_CTRL: cmd = OP_CTRL;
        PAT_ENTRY: cmd = OP_ENTRY;
        PAT_HOME: cmd = OP_HOME;
        PAT_CLEAR: cmd = OP_CLEAR;
        default: cmd = OP_NOP;
      endcase
    end
  end

  // Waits for busy and the half-period guard to run out
  assign exec_go = pend_q & (busy_cnt_q == '0) & (guard_cnt_q == '0) &
    (state_q == ST_IDLE);

  // ==========================================================================
  // Busy timing
  // ==========================================================================
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt_q <= '0;
    end else if (exec_go) begin
      case (cmd)
        OP_CLEAR, OP_HOME: busy_cnt_q <= BUSY_W'(LONG_CYCLES);
        OP_WRITE, OP_READ: busy_cnt_q <= BUSY_W'(DATA_CYC);
        OP_NOP: busy_cnt_q <= '0;
        default: busy_cnt_q <= BUSY_W'(INSTR_CYC);
      endcase
    end else if (busy_cnt_q != '0) begin
      busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      guard_cnt_q <= '0;
    end else if (busy_cnt_q == BUSY_W'(1)) begin
      guard_cnt_q <= GUARD_W'(HALF_OSC_CYC);
    end else if (guard_cnt_q != '0) begin
      guard_cnt_q <= guard_cnt_q - GUARD_W'(1);
    end
  end

  // Queued work counts as busy so a poll never sees a false idle
  assign busy_ind = (busy_cnt_q != '0) | pend_q | (state_q != ST_IDLE);

  // ==========================================================================
  // Mode registers
  // ==========================================================================
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      incr_q <= 1'b1;
      whole_screen_move_q <= 1'b0;
    end else if (exec_go && cmd == OP_CLEAR) begin
      incr_q <= 1'b1;
    end else if (exec_go && cmd == OP_ENTRY) begin
      incr_q <= pend_byte_q[B_INCR];
      whole_screen_move_q <= pend_byte_q[B_MOVE];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      display_on_q <= 1'b0;
      cursor_on_q <= 1'b0;
      blink_on_q <= 1'b0;
    end else if (exec_go && cmd == OP_CTRL) begin
      display_on_q <= pend_byte_q[B_DISP];
      cursor_on_q <= pend_byte_q[B_CURS];
      blink_on_q <= pend_byte_q[B_BLINK];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_width_sel_q <= 1'b1;
      two_line_q <= 1'b0;
      tall_font_q <= 1'b0;
    end else if (exec_go && cmd == OP_FORMAT) begin
      bus_width_sel_q <= pend_byte_q[B_WIDTH];
      two_line_q <= pend_byte_q[B_LINES];
      tall_font_q <= pend_byte_q[B_FONT];
    end
  end

  // ==========================================================================
  // Address counter and RAM select
  // ==========================================================================
  logic [6:0] addr_counter_q;
  logic [6:0] addr_counter_d;
  logic [6:0] addr_step;
  logic glyph_sel_q;
  logic glyph_sel_d;

  assign addr_step = incr_q ? addr_counter_q + 7'h01 : addr_counter_q - 7'h01;

  always_comb begin
    addr_counter_d = addr_counter_q;
    glyph_sel_d = glyph_sel_q;
    if (exec_go) begin
      case (cmd)
        OP_CLEAR, OP_HOME: begin
          addr_counter_d = HOME_ADDR;
          glyph_sel_d = 1'b0;
        end
        OP_SHIFT: begin
          if (!pend_byte_q[B_SC]) begin
            addr_counter_d = pend_byte_q[B_RL] ? addr_counter_q + 7'h01 :
              addr_counter_q - 7'h01;
          end
        end
        OP_GLYPH_ADDR: begin
          addr_counter_d = {1'b0, pend_byte_q[GLYPH_ADDR_W-1:0]};
          glyph_sel_d = 1'b1;
        end
        OP_DISP_ADDR: begin
          addr_counter_d = pend_byte_q[DISP_ADDR_W-1:0];
          glyph_sel_d = 1'b0;
        end
        OP_WRITE, OP_READ: addr_counter_d = addr_step;
        default: addr_counter_d = addr_counter_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_counter_q <= HOME_ADDR;
      glyph_sel_q <= 1'b0;
    end else begin
      addr_counter_q <= addr_counter_d;
      glyph_sel_q <= glyph_sel_d;
    end
  end

  // ==========================================================================
  // Display shift offset
  // ==========================================================================
  logic [6:0] shift_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_q <= 7'h00;
    end else if (exec_go) begin
      case (cmd)
        OP_CLEAR, OP_HOME: shift_q <= 7'h00;
        OP_SHIFT: begin
          if (pend_byte_q[B_SC]) begin
            shift_q <= pend_byte_q[B_RL] ? shift_q - 7'h01 : shift_q + 7'h01;
          end
        end
        OP_WRITE: begin
          if (whole_screen_move_q && !glyph_sel_q) begin
            shift_q <= incr_q ? shift_q + 7'h01 : shift_q - 7'h01;
          end
        end
        default: shift_q <= shift_q;
      endcase
    end
  end

  // ==========================================================================
  // RAMs and data register
  // ==========================================================================
  logic [7:0] disp_mem [0:127];
  logic [7:0] glyph_mem [0:63];
  logic [6:0] fill_q;
  logic disp_we;
  logic [6:0] disp_waddr;
  logic [7:0] disp_wdata;
  logic glyph_we;
  logic [7:0] data_reg_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      fill_q <= 7'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (exec_go && cmd == OP_CLEAR) begin
            state_q <= ST_FILL;
            fill_q <= 7'h00;
          end
        end
        ST_FILL: begin
          fill_q <= fill_q + 7'h01;
          if (fill_q == FILL_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Clear walks every location; the walk is far shorter than the busy time
  always_comb begin
    disp_we = 1'b0;
    disp_waddr = addr_counter_q;
    disp_wdata = pend_byte_q;
    if (state_q == ST_FILL) begin
      disp_we = 1'b1;
      disp_waddr = fill_q;
      disp_wdata = SPACE_CODE;
    end else if (exec_go && cmd == OP_WRITE && !glyph_sel_q) begin
      disp_we = 1'b1;
    end
  end

  assign glyph_we = exec_go & (cmd == OP_WRITE) & glyph_sel_q;

  always_ff @(posedge clk_sys_i) begin
    if (disp_we) begin
      disp_mem[disp_waddr] <= disp_wdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (glyph_we) begin
      glyph_mem[addr_counter_q[GLYPH_ADDR_W-1:0]] <= pend_byte_q;
    end
  end

  // Prefetch at the new address, so reads return data one access ahead
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_reg_q <= 8'h00;
    end else if (exec_go && (cmd == OP_READ || cmd == OP_GLYPH_ADDR ||
        cmd == OP_DISP_ADDR || cmd == OP_SHIFT)) begin
      data_reg_q <= glyph_sel_d ? glyph_mem[addr_counter_d[GLYPH_ADDR_W-1:0]] :
        disp_mem[addr_counter_d];
    end
  end

  // ==========================================================================
  // Host read drive
  // ==========================================================================
  logic [7:0] rd_byte;

  assign rd_byte = rs_s ? data_reg_q : {busy_ind, addr_counter_q};

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_o <= 8'h00;
      bus_oe_n_o <= 1'b1;
    end else begin
      bus_oe_n_o <= ~(en_s & rw_s);
      if (bus_width_sel_q) begin
        bus_o <= rd_byte;
      end else begin
        bus_o <= {nib_q ? rd_byte[3:0] : rd_byte[7:4], 4'h0};
      end
    end
  end

  // ==========================================================================
  // Wishbone slave
  // ==========================================================================
  logic [6:0] view_addr_q;
  logic [6:0] view_idx;
  logic [7:0] view_char;
  logic wb_hit;
  logic [31:0] status_word;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign view_idx = view_addr_q + shift_q;
  assign view_char = display_on_q ? disp_mem[view_idx] : SPACE_CODE;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[DISP_ADDR_W-1:0] = addr_counter_q;
    status_word[S_BUSY] = busy_ind;
    status_word[S_DISP] = display_on_q;
    status_word[S_CURS] = cursor_on_q;
    status_word[S_BLINK] = blink_on_q;
    status_word[S_INCR] = incr_q;
    status_word[S_MOVE] = whole_screen_move_q;
    status_word[S_WIDTH] = bus_width_sel_q;
    status_word[S_LINES] = two_line_q;
    status_word[S_FONT] = tall_font_q;
    status_word[S_OFFSET +: DISP_ADDR_W] = shift_q;
    status_word[S_GLYPH] = glyph_sel_q;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          OFS_STATUS: wb_dat_o <= status_word;
          OFS_VIEW_ADDR: wb_dat_o <= {25'h0000000, view_addr_q};
          OFS_VIEW_DATA: wb_dat_o <= {24'h000000, view_char};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      view_addr_q <= 7'h00;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
        wb_adr_i == OFS_VIEW_ADDR && wb_sel_i[0]) begin
      view_addr_q <= wb_dat_i[DISP_ADDR_W-1:0];
    end
  end

endmodule

// File: tb/char_lcd_sva.sv
// Purpose: Port checks for the display instruction decoder
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to the design top after the module
`timescale 1ns/1ps
module char_lcd_sva
  import char_lcd_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = LONG_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic read_not_write_i,
  input wire logic strobe_i,
  input wire logic bus_oe_n_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  logic rd_ack, hole_rd, st_rd, vd_rd;
  // ==========
  // Sequences
  // ==========
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_held;
    (strobe_i && read_not_write_i) [*5];
  endsequence
  sequence s_idle_held;
    !strobe_i [*5];
  endsequence
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign hole_rd = rd_ack && !(wb_adr_i inside {OFS_STATUS, OFS_VIEW_ADDR, OFS_VIEW_DATA});
  assign st_rd = rd_ack && wb_adr_i == OFS_STATUS;
  assign vd_rd = rd_ack && wb_adr_i == OFS_VIEW_DATA;
  // ==========
  // Properties
  // ==========
  a_ack_next: assert property (s_wb_req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_hole_zero: assert property (hole_rd |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_top: assert property (st_rd |-> wb_dat_o[31:24] == 8'h00)
    else $error("status upper byte set");
  a_view_width: assert property (vd_rd |-> wb_dat_o[31:8] == 24'h0)
    else $error("view data wider than a byte");
  a_drive_read: assert property (s_rd_held |-> !bus_oe_n_o)
    else $error("bus not driven on read");
  a_release_bus: assert property (s_idle_held |-> bus_oe_n_o)
    else $error("bus held after strobe");
  a_drive_cause: assert property (!bus_oe_n_o |-> $past(read_not_write_i, 3))
    else $error("bus driven on write");
endmodule

bind char_lcd_instruction_decoder char_lcd_sva #(.LONG_CYCLES(LONG_CYCLES)) i_sva (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .read_not_write_i(read_not_write_i),
  .strobe_i(strobe_i), .bus_oe_n_o(bus_oe_n_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// File: tb/host_model.sv
// Purpose: Host processor model on the parallel display bus
// Assumes: Busy is polled before every instruction or data byte
// Notes: A released bus reads back toggling, never a stale copy
`timescale 1ns/1ps
module host_model
  import char_lcd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [7:0] dev_bus_i,
  input wire logic dev_oe_n_i,
  output logic reg_select_o = 1'b0,
  output logic read_not_write_o = 1'b0,
  output logic strobe_o = 1'b0,
  output logic [7:0] line_o
);
  logic [7:0] drv_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic drive_q = 1'b0;
  logic nib4_q = 1'b0;
  assign line_o = !dev_oe_n_i ? dev_bus_i : (drive_q ? drv_q : ~last_q);
  always_ff @(posedge clk_sys_i) begin
    last_q <= line_o;
  end
  // ==========
  // Strobe cycle
  // ==========
  // Data held 125 ns past the fall; cycle padded past 1200 ns
  task automatic pulse(input logic rs, input logic rnw, input logic [7:0] d,
                       output logic [7:0] q);
    reg_select_o <= rs;
    read_not_write_o <= rnw;
    drv_q <= d;
    drive_q <= !rnw;
    repeat (2) @(posedge clk_sys_i);
    strobe_o <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    q = line_o;
    strobe_o <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    drive_q <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
  endtask
  task automatic xfer(input logic rs, input logic rnw, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (nib4_q) begin
      pulse(rs, rnw, {d[7:4], 4'h0}, hi);
      pulse(rs, rnw, {d[3:0], 4'h0}, lo);
      q = {hi[7:4], lo[7:4]};
    end else begin
      pulse(rs, rnw, d, q);
    end
  endtask
  // ==========
  // Host operations
  // ==========
  task automatic status(output logic [7:0] q);
    xfer(1'b0, 1'b1, 8'h00, q);
  endtask
  task automatic ready();
    logic [7:0] q;
    q = 8'hff;
    for (int i = 0; i < 100 && q[7] !== 1'b0; i++) begin
      status(q);
    end
    repeat (HALF_OSC_CYC) @(posedge clk_sys_i);
  endtask
  task automatic send(input logic rs, input logic [7:0] d);
    logic [7:0] q;
    ready();
    xfer(rs, 1'b0, d, q);
  endtask
  task automatic get(output logic [7:0] q);
    ready();
    xfer(1'b1, 1'b1, 8'h00, q);
  endtask
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench for the display instruction decoder
// Assumes: Clear/home count cut to 300 cycles to keep the run short
// Notes: Panel state is seen through the Wishbone view registers
`timescale 1ns/1ps
module testbench
  import char_lcd_pkg::*;
;
  localparam int LONG_T = 300;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_select_i;
  logic read_not_write_i;
  logic strobe_i;
  logic [7:0] pin_bus;
  logic [7:0] bus_o;
  logic bus_oe_n_o;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] w;
  logic [7:0] q;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  host_model i_host (.clk_sys_i(clk_sys_i), .dev_bus_i(bus_o), .dev_oe_n_i(bus_oe_n_o),
    .reg_select_o(reg_select_i), .read_not_write_o(read_not_write_i), .strobe_o(strobe_i),
    .line_o(pin_bus));
  char_lcd_instruction_decoder #(.LONG_CYCLES(LONG_T)) i_dut (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .reg_select_i(reg_select_i), .read_not_write_i(read_not_write_i),
    .strobe_i(strobe_i), .bus_i(pin_bus), .bus_o(bus_o), .bus_oe_n_o(bus_oe_n_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  // ==========
  // Tasks
  // ==========
  task automatic cmp(input string s, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    @(posedge clk_sys_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys_i);
    w = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // Window is loose by a poll; the three figures differ by far more
  task automatic busy_len(input int n);
    time t0;
    t0 = $time;
    w = 32'h80;
    while (w[S_BUSY] === 1'b1) wb(1'b0, OFS_STATUS, 32'h0);
    cmp("busy span", (($time - t0) / 25) inside {[n - 46 : n - 33]}, 1'b1);
  endtask
  task automatic summarize();
    $display("num_errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      summarize();
    end
  end
  // ==========
  // Sequence
  // ==========
  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp("reset status", w, 32'h0000_2800);
    wb(1'b0, 4'hc, 32'h0);
    cmp("unmapped", w, 32'h0);
    wb(1'b1, OFS_VIEW_ADDR, 32'h05);
    wb(1'b0, OFS_VIEW_ADDR, 32'h0);
    cmp("view addr", w, 32'h05);
    i_host.send(1'b0, 8'h0e);
    i_host.send(1'b0, 8'h3c);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp("controls", w[10:8], 3'b011);
    cmp("format", w[15:13], 3'b111);
    i_host.send(1'b0, 8'h04);
    i_host.send(1'b0, 8'h01);
    busy_len(LONG_T);
    i_host.status(q);
    cmp("clear addr", q, 8'h00);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp("clear incr", w[S_INCR], 1'b1);
    wb(1'b0, OFS_VIEW_DATA, 32'h0);
    cmp("clear fill", w, 32'h20);
    i_host.send(1'b0, 8'h90);
    i_host.send(1'b1, 8'h41);
    busy_len(DATA_CYC);
    i_host.send(1'b1, 8'h42);
    i_host.status(q);
    cmp("busy high", q[7], 1'b1);
    i_host.ready();
    i_host.status(q);
    cmp("write step", q, 8'h12);
    wb(1'b1, OFS_VIEW_ADDR, 32'h10);
    wb(1'b0, OFS_VIEW_DATA, 32'h0);
    cmp("stored", w, 32'h41);
    i_host.send(1'b0, 8'h91);
    i_host.get(q);
    cmp("read", q, 8'h42);
    i_host.send(1'b0, 8'h04);
    i_host.send(1'b1, 8'h43);
    busy_len(DATA_CYC);
    i_host.status(q);
    cmp("decrement", q, 8'h11);
    i_host.send(1'b0, 8'h07);
    i_host.send(1'b1, 8'h44);
    i_host.get(q);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp("move on write", w[22:16], 7'h01);
    cmp("read step", w[6:0], 7'h13);
    i_host.send(1'b0, 8'h18);
    busy_len(INSTR_CYC);
    i_host.send(1'b0, 8'h14);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp("shift", {w[22:16], w[6:0]}, {7'h02, 7'h14});
    i_host.send(1'b0, 8'h02);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp("home", {w[22:16], w[6:0]}, 14'h0);
    wb(1'b0, OFS_VIEW_DATA, 32'h0);
    cmp("home ram", w, 32'h41);
    i_host.send(1'b0, 8'h08);
    wb(1'b0, OFS_VIEW_DATA, 32'h0);
    cmp("blank", w, 32'h20);
    i_host.send(1'b0, 8'h0c);
    wb(1'b0, OFS_VIEW_DATA, 32'h0);
    cmp("unblank", w, 32'h41);
    i_host.send(1'b0, 8'h45);
    i_host.send(1'b1, 8'h1f);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp("glyph", {w[23:16], w[6:0]}, {8'h80, 7'h06});
    i_host.send(1'b0, 8'h45);
    i_host.get(q);
    cmp("glyph read", q, 8'h1f);
    i_host.send(1'b0, 8'h28);
    i_host.nib4_q = 1'b1;
    i_host.send(1'b0, 8'ha5);
    i_host.ready();
    i_host.status(q);
    cmp("nibbles", q, 8'h25);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp("narrow", w[S_WIDTH], 1'b0);
    summarize();
  end
endmodule
